// >>> shared/dac_ctrl_pkg.sv
// constants for the quad converter control block
// assumes a 50 MHz system clock sampling the serial link pins
package dac_ctrl_pkg;
   // ---------------------------------------------------------------
   // frame layout (kept configurable)
   // ---------------------------------------------------------------
   localparam int FRAME_BITS = 12;
   localparam logic [3:0] FRAME_LAST = 4'hB;
   localparam int KIND_POS = 11;       // 1 = control word, 0 = data word
   localparam int SEL1_POS = 10;
   localparam int SEL0_POS = 9;
   localparam int RANGE_POS = 8;
   localparam int DATA_MSB = 7;
   localparam int CTRL_MSB = 9;        // control bits sit in frame [9:0]
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTRL_WIDTH = 10;
   localparam int MODE_POS = 9;
   localparam int RANGE_LSB = 5;       // range a..d at [5..8]
   localparam int INHIBIT_LSB = 1;     // inhibit a..d at [1..4]
   localparam int ACTIVE_POS = 0;
   localparam logic [9:0] CTRL_RESET = 10'h1E0;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam int NUM_CHAN = 4;
endpackage

// >>> design/sync_two_ff.sv
// two-flop synchroniser for asynchronous pin levels
// assumes the pin is held stable for at least two clk_sys periods
`timescale 1ns/1ps
module sync_two_ff
   import dac_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // level in and out
   input wire logic pinIn,
   output logic levelOut
);
   logic stage1_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stage1_reg <= 1'b0;
         levelOut <= 1'b0;
      end else begin
         stage1_reg <= pinIn;
         levelOut <= stage1_reg;
      end
   end
endmodule

// >>> design/quad_dac_control.sv
// serial control logic of a quad 8-bit converter: shift register, control
// register, input/output code latches and per-channel shutdown
// assumes serial clock, data, strobe and activate pin are asynchronous pins
`timescale 1ns/1ps
module quad_dac_control
   import dac_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // serial link pins and hardware activate pin
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic loadStrobe,
   input wire logic hw_activate_pin,
   // converter channel codes
   output logic [7:0] out_chan_a,
   output logic [7:0] out_chan_b,
   output logic [7:0] out_chan_c,
   output logic [7:0] out_chan_d,
   // gain and power state per channel (index 0 = a), and the buffer mode
   output logic [3:0] gainDouble,
   output logic [3:0] chanActive,
   output logic singleBuffered
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic clkSync;
   logic dataSync;
   logic strobeSync;
   logic actSync;
   // every pin passes two flops before any logic reads it
   sync_two_ff uSyncClk (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(serialClk),
      .levelOut(clkSync)
   );
   sync_two_ff uSyncData (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(serialData),
      .levelOut(dataSync)
   );
   sync_two_ff uSyncStb (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(loadStrobe),
      .levelOut(strobeSync)
   );
   sync_two_ff uSyncAct (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(hw_activate_pin),
      .levelOut(actSync)
   );

   // ---------------------------------------------------------------
   // edge detection
   // ---------------------------------------------------------------
   // reset levels match the idle pins, so no false edge follows reset
   logic clkPrev_reg;
   logic strobePrev_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clkPrev_reg <= 1'b0;
      end else begin
         clkPrev_reg <= clkSync;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         strobePrev_reg <= 1'b0;
      end else begin
         strobePrev_reg <= strobeSync;
      end
   end
   wire clkFall = clkPrev_reg & ~clkSync;
   wire shiftEn = clkFall & strobeSync;
   wire strobeFall = strobePrev_reg & ~strobeSync;

   // ---------------------------------------------------------------
   // shift register and bit counter
   // ---------------------------------------------------------------
   logic [FRAME_BITS-1:0] shift_reg;
   logic [FRAME_BITS-1:0] shift_next;
   logic [3:0] count_reg;
   logic [3:0] count_next;
   // msb arrives first and ends at the top of the frame
   assign shift_next = {shift_reg[FRAME_BITS-2:0], dataSync};
   wire lastBit = shiftEn & (count_reg == FRAME_LAST);
   assign count_next = lastBit ? 4'h0 : count_reg + 4'h1;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shift_reg <= '0;
      end else if (shiftEn) begin
         shift_reg <= shift_next;
      end
   end
   // strobe low clears the count, so a cut word is never completed
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count_reg <= 4'h0;
      end else if (shiftEn) begin
         count_reg <= count_next;
      end else if (!strobeSync) begin
         count_reg <= 4'h0;
      end
   end

   // ---------------------------------------------------------------
   // word decode
   // ---------------------------------------------------------------
   // bit positions live in the package so the layout can move
   wire isCtrl = shift_next[KIND_POS];
   wire wordCtrl = lastBit & isCtrl;
   wire wordData = lastBit & ~isCtrl;
   wire [1:0] chanSel = {shift_next[SEL1_POS], shift_next[SEL0_POS]};
   wire [7:0] wordCode = shift_next[DATA_MSB:0];
   // range bit of a data word is ignored; gain follows the control register

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   // write-only: nothing reads it back over the link
   logic [CTRL_WIDTH-1:0] ctrl_reg;
   logic [CTRL_WIDTH-1:0] ctrl_next;
   wire [CTRL_WIDTH-1:0] ctrlWord = shift_next[CTRL_MSB:0];
   // mode is sticky: a later control word may not clear it
   assign ctrl_next = {ctrlWord[MODE_POS] | ctrl_reg[MODE_POS],
      ctrlWord[MODE_POS-1:0]};
   wire modeSingle = ctrl_reg[MODE_POS];
   wire softActive = ctrl_reg[ACTIVE_POS];
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wordCtrl) begin
         ctrl_reg <= ctrl_next;
      end
   end
   // the mode decision for the word's own end uses the incoming word too
   wire singleNow = ctrl_next[MODE_POS];

   // ---------------------------------------------------------------
   // per-channel latches
   // ---------------------------------------------------------------
   // input latches keep the newest word per channel until an update
   logic [7:0] inCode_reg [NUM_CHAN];
   logic [7:0] outCode_reg [NUM_CHAN];
   logic [NUM_CHAN-1:0] gain_reg;
   logic [NUM_CHAN-1:0] active_reg;
   // single mode: latch at the word's last edge; double: at strobe fall
   wire updateAll = (lastBit & (modeSingle | (wordCtrl & singleNow)))
      | (strobeFall & ~modeSingle);

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++) begin : gChan
         wire hit = wordData & (chanSel == 2'(ch));
         wire [7:0] codeNext = hit ? wordCode : inCode_reg[ch];
         wire inhibit = ctrl_reg[INHIBIT_LSB+ch];
         // pin is synchronised: a few clocks late, but needs no link edge
         wire actNext = inhibit | (softActive & actSync);
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               inCode_reg[ch] <= CODE_RESET;
            end else if (hit) begin
               inCode_reg[ch] <= wordCode;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               outCode_reg[ch] <= CODE_RESET;
            end else if (updateAll) begin
               outCode_reg[ch] <= codeNext;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               gain_reg[ch] <= CTRL_RESET[RANGE_LSB+ch];
            end else begin
               gain_reg[ch] <= ctrl_reg[RANGE_LSB+ch];
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               active_reg[ch] <= 1'b0;
            end else begin
               active_reg[ch] <= actNext;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // every output is a flop; the mode output is the register bit itself
   assign out_chan_a = outCode_reg[0];
   assign out_chan_b = outCode_reg[1];
   assign out_chan_c = outCode_reg[2];
   assign out_chan_d = outCode_reg[3];
   assign gainDouble = gain_reg;
   assign chanActive = active_reg;
   assign singleBuffered = ctrl_reg[MODE_POS];
endmodule

// >>> sim/quad_dac_control_asserts.sv
// checker for the quad converter control block
// sees only the top module ports; bound at the foot of this file
`timescale 1ns/1ps
module quad_dac_control_asserts
   import dac_ctrl_pkg::*;
(
   // clock, reset and pins
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic loadStrobe,
   input wire logic hw_activate_pin,
   // outputs
   input wire logic [7:0] out_chan_a,
   input wire logic [7:0] out_chan_b,
   input wire logic [7:0] out_chan_c,
   input wire logic [7:0] out_chan_d,
   input wire logic [3:0] gainDouble,
   input wire logic [3:0] chanActive,
   input wire logic singleBuffered
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // reset checks must see the reset itself, so no disable there
   a_reset_shut: assert property (disable iff (1'b0) !rst_n |=> chanActive == 4'h0)
      else $error("channel active after reset");
   a_reset_cfg: assert property (disable iff (1'b0) !rst_n |=> gainDouble == 4'hF
      && !singleBuffered && out_chan_a == 8'h00) else $error("bad reset config");
   a_mode_sticky: assert property (singleBuffered |=> singleBuffered)
      else $error("mode bit cleared");
   a_active_quiet: assert property ((!loadStrobe && $stable(hw_activate_pin))[*8]
      |-> $stable(chanActive)) else $error("active changed with no cause");
   a_out_quiet: assert property ((!loadStrobe)[*8] |-> $stable({out_chan_a, out_chan_b,
      out_chan_c, out_chan_d, gainDouble})) else $error("output moved while idle");
   a_mode_set: assert property ($rose(singleBuffered) |-> $past(loadStrobe, 2))
      else $error("mode set without strobe");
   a_double_hold: assert property (!singleBuffered && $changed(out_chan_a) |-> !loadStrobe)
      else $error("double mode update before strobe fall");
   a_single_update: assert property (singleBuffered && $changed(out_chan_b)
      |-> $past(loadStrobe, 2)) else $error("single mode update outside word");
   cover property ($rose(singleBuffered));
   cover property ($rose(chanActive[0]));
   cover property ($changed(out_chan_d));
   cover property (!loadStrobe && $changed(chanActive));
   cover property (!singleBuffered && $changed(out_chan_a));
endmodule
bind quad_dac_control quad_dac_control_asserts i_chk (.clk_sys, .rst_n, .serialClk,
   .serialData, .loadStrobe, .hw_activate_pin, .out_chan_a, .out_chan_b, .out_chan_c,
   .out_chan_d, .gainDouble, .chanActive, .singleBuffered);

// >>> sim/host_link_model.sv
// host side of the serial link: clock, data and load strobe
// assumes the caller starts a frame only once the previous one is done
`timescale 1ns/1ps
module host_link_model (
   // serial pins
   output logic serialClk,
   output logic serialData,
   output logic loadStrobe
);
   initial begin
      serialClk = 1'b0;
      serialData = 1'b0;
      loadStrobe = 1'b0;
   end
   // msb first, n bits; clock stands low outside frames
   task automatic frame(input logic [11:0] w, input int n);
      int i;
      loadStrobe = 1'b1;
      #40;
      for (i = 11; i > 11 - n; i--) begin
         serialClk = 1'b1;
         serialData = w[i];
         #80 serialClk = 1'b0;
         #80;
      end
      // released data line shows the inverse, never a stale level
      serialData = ~serialData;
      #40;
   endtask
   task automatic drop;
      loadStrobe = 1'b0;
      #240;
   endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the quad converter control block
// assumes the host link model drives all serial pins
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench
   import dac_ctrl_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hw_activate_pin = 1'b0;
   logic serialClk, serialData, loadStrobe, singleBuffered;
   logic [7:0] out_chan_a, out_chan_b, out_chan_c, out_chan_d;
   logic [3:0] gainDouble, chanActive;
   logic [9:0] ctl;
   logic [7:0] inl [4];
   logic [7:0] outl [4];
   int fails = 0, check_count = 0, cyc = 0, seed = 82443, k;
   always #10 clk_sys = ~clk_sys;
   quad_dac_control i_quad_dac_control (.clk_sys, .rst_n, .serialClk, .serialData,
      .loadStrobe, .hw_activate_pin, .out_chan_a, .out_chan_b, .out_chan_c, .out_chan_d,
      .gainDouble, .chanActive, .singleBuffered);
   host_link_model i_host (.serialClk, .serialData, .loadStrobe);
   function automatic logic [3:0] act(input logic [9:0] c, input logic p);
      return c[4:1] | {4{c[0] & p}};
   endfunction
   task automatic put(input logic [11:0] w);
      i_host.frame(w, FRAME_BITS);
      if (w[KIND_POS]) ctl = {ctl[MODE_POS] | w[MODE_POS], w[8:0]};
      else inl[w[SEL1_POS -: 2]] = w[DATA_MSB:0];
      if (ctl[MODE_POS]) outl = inl;
   endtask
   task automatic drop;
      i_host.drop();
      outl = inl;
   endtask
   task automatic chk;
      repeat (10) @(negedge clk_sys);
      `CHK({out_chan_a, out_chan_b, out_chan_c, out_chan_d}, {outl[0], outl[1], outl[2], outl[3]})
      `CHK(gainDouble, ctl[8:5])
      `CHK(chanActive, act(ctl, hw_activate_pin))
      `CHK(singleBuffered, ctl[MODE_POS])
   endtask
   task automatic rst;
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      ctl = CTRL_RESET;
      foreach (inl[i]) inl[i] = CODE_RESET;
      outl = inl;
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic final_report;
      if (fails == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      rst();
      chk();
      // data words to every channel, overwrites before a strobe fall
      for (k = 0; k < 20; k++) begin
         @(negedge clk_sys) hw_activate_pin = 1'($random(seed));
         put({1'b0, k[1:0], 9'($random(seed))});
         if (k % 3 == 2) put({3'b100, 9'($random(seed))});
         chk();
         if (k % 5 == 4) begin
            drop();
            chk();
         end
      end
      i_host.frame(12'h3FF, 5);
      i_host.drop();
      chk();
      // activate pin alone, link idle: a, b held active by their inhibit bits, c, d follow the pin
      put({3'b100, 9'h007});
      drop();
      for (k = 0; k < 4; k++) begin
         @(negedge clk_sys) hw_activate_pin = ~hw_activate_pin;
         chk();
      end
      put({2'b10, 10'h200 | 10'($random(seed))});
      put({3'b001, 9'($random(seed))});
      chk();
      put(12'h800);
      chk();
      rst();
      chk();
      final_report();
   end
endmodule
